// ==== src/rac_alarm.sv ====
// Minutes/seconds timekeeping, calibration and alarm engine with APB registers
`timescale 1ns/1ps
// Notes on behaviour
// - Time minutes/seconds held as BCD tens/ones digits in two bytes.
// - Alarm minutes/seconds uses same BCD layout; bits 15 and 7 read zero.
// - Alarm month/day: month tens bit 12, ones 11-8, day digits 5-0.
// - Alarm weekday/hours: weekday 10-8, hour digits 5-0, rest zero.
// - Alarm month/day and weekday/hours writes need clock write enable.
// - Each minute timer shifts by four times signed calibration byte.
// - Negative calibration adds pulses, slowing a fast oscillator.
// - Alarm runs only while enabled; final alarm clears the enable.
// - Four-bit mask picks matched digits, half second to yearly.
// - Repeat count zero without chime gives one alarm; FFh gives 256.
// - Counter decrements per alarm; at zero last alarm disables.
// - With chime set counter wraps zero to FFh, alarms continue.
// - Every alarm event raises an interrupt request.
// - Alarm pulse output toggles on each alarm, half alarm rate.
// - Window pointer selects value register, decrements to 00 per read or upper-byte write.
// - Yearly mask fires yearly; February 29 fires every four years.
module rac_alarm #(
    parameter int unsigned OSC_DIV     = rac_pkg::OSC_DIV_CYC,
    parameter int unsigned HALF_PULSES = rac_pkg::HALF_SEC_PULSES
) (
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic [15:0] cur_weekday_hours,
    input  wire logic [15:0] cur_month_day,
    output logic             alarm_irq,
    output logic             alarm_pulse,
    output logic             minute_carry
);
    // ==================================================================
    // Parameter checks
    initial begin
        if (OSC_DIV < 1 || OSC_DIV > 65535 || HALF_PULSES <= 512 || HALF_PULSES > 65536) begin
            $error("rac_alarm: unsupported OSC_DIV or HALF_PULSES");
        end
    end

    localparam logic [15:0] DIV_LAST  = 16'(OSC_DIV - 1);
    localparam logic [17:0] HALF_LAST = 18'(HALF_PULSES - 1);

    typedef struct packed {
        logic [15:0] div;
        logic [17:0] presc;
        logic        half;
        logic [15:0] time_ms;
        logic        run;
        logic        wren;
        logic [7:0]  cal;
        logic        al_en;
        logic        chime;
        logic [3:0]  mask;
        logic [1:0]  ptr;
        logic [7:0]  rpt;
        logic [15:0] al_md;
        logic [15:0] al_wh;
        logic [15:0] al_ms;
        logic        tick;
        logic        irq;
        logic        pulse;
        logic        min_pulse;
        logic [31:0] rdata;
        logic        err;
    } rac_state_s;

    rac_state_s s_q;
    rac_state_s s_d;

    // ==================================================================
    // Helpers
    function automatic logic [7:0] inc_sexa(input logic [6:0] v);
        // Returns {carry, next} for a two-digit BCD value 00..59
        if (v[3:0] == 4'h9) begin
            if (v[6:4] == 3'h5) begin
                return {1'b1, 7'h00};
            end
            return {1'b0, v[6:4] + 3'h1, 4'h0};
        end
        return {1'b0, v[6:4], v[3:0] + 4'h1};
    endfunction

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb, input logic [15:0] bits);
        logic [15:0] r;
        r = old;
        if (strb[0]) begin
            r[7:0] = wd[7:0];
        end
        if (strb[1]) begin
            r[15:8] = wd[15:8];
        end
        return r & bits;
    endfunction

    function automatic logic known_addr(input logic [7:0] a);
        return a == rac_pkg::ADDR_CTRL_CAL || a == rac_pkg::ADDR_ALARM_CFG
            || a == rac_pkg::ADDR_ALARM_PORT || a == rac_pkg::ADDR_TIME_MS
            || a == rac_pkg::ADDR_AL_MD || a == rac_pkg::ADDR_AL_WH
            || a == rac_pkg::ADDR_AL_MS;
    endfunction

    function automatic logic [15:0] port_view(input rac_state_s s);
        logic [15:0] v;
        case (s.ptr)
            rac_pkg::PTR_MIN_SEC: v = s.al_ms;
            rac_pkg::PTR_WDHR:   v = s.al_wh;
            rac_pkg::PTR_MTHDY:  v = s.al_md;
            default:             v = 16'h0000;
        endcase
        return v;
    endfunction

    // Digits compared against the alarm, widening with the mask code
    function automatic logic mask_match(input rac_state_s s, input logic [15:0] wh,
                                        input logic [15:0] md);
        logic sec_b;
        logic ms_ok;
        sec_b = !s.half;
        ms_ok = s.time_ms == s.al_ms;
        case (s.mask)
            rac_pkg::RAC_M_HALF:  return 1'b1;
            rac_pkg::RAC_M_SEC:   return sec_b;
            rac_pkg::RAC_M_10SEC: return sec_b && s.time_ms[3:0] == s.al_ms[3:0];
            rac_pkg::RAC_M_MIN:   return sec_b && s.time_ms[6:0] == s.al_ms[6:0];
            rac_pkg::RAC_M_10MIN: return sec_b && s.time_ms[11:0] == s.al_ms[11:0];
            rac_pkg::RAC_M_HOUR:  return sec_b && ms_ok;
            rac_pkg::RAC_M_DAY:   return sec_b && ms_ok && wh[5:0] == s.al_wh[5:0];
            rac_pkg::RAC_M_WEEK:  return sec_b && ms_ok && wh == s.al_wh;
            rac_pkg::RAC_M_MONTH: return sec_b && ms_ok && wh[5:0] == s.al_wh[5:0]
                                         && md[5:0] == s.al_md[5:0];
            rac_pkg::RAC_M_YEAR:  return sec_b && ms_ok && wh[5:0] == s.al_wh[5:0]
                                         && md == s.al_md;
            default:              return 1'b0;
        endcase
    endfunction

    // ==================================================================
    // Next-state logic
    logic        setup;
    logic        wr_acc;
    logic        rd_acc;
    logic        osc;
    logic        tick;
    logic [7:0]  sec_n;
    logic [7:0]  min_n;
    logic [15:0] md_w;
    logic [15:0] wh_w;

    assign setup  = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign sec_n  = inc_sexa(s_q.time_ms[6:0]);
    assign min_n  = inc_sexa(s_q.time_ms[14:8]);
    assign md_w   = merge(s_q.al_md, pwdata, pstrb, rac_pkg::MD_BITS);
    assign wh_w   = merge(s_q.al_wh, pwdata, pstrb, rac_pkg::WH_BITS);

    always_comb begin
        s_d           = s_q;
        s_d.irq       = 1'b0;
        s_d.min_pulse = 1'b0;
        osc           = 1'b0;
        tick          = 1'b0;
        // Oscillator pulse divider and half-second prescaler
        if (s_q.run) begin
            if (s_q.div == DIV_LAST) begin
                s_d.div = 16'h0000;
                osc     = 1'b1;
            end else begin
                s_d.div = s_q.div + 16'h0001;
            end
        end
        if (osc) begin
            if (s_q.presc == HALF_LAST) begin
                s_d.presc = 18'h00000;
                tick      = 1'b1;
            end else begin
                s_d.presc = s_q.presc + 18'h00001;
            end
        end
        if (tick) begin
            s_d.half = !s_q.half;
            if (s_q.half) begin
                s_d.time_ms[6:0] = sec_n[6:0];
                if (sec_n[7]) begin
                    s_d.time_ms[14:8] = min_n[6:0];
                    s_d.min_pulse     = min_n[7];
                    // Signed start point shifts the next second's length
                    s_d.presc = {{8{s_q.cal[7]}}, s_q.cal, 2'b00};
                end
            end
        end
        s_d.tick = tick;

        // Register writes take effect at the access edge
        if (wr_acc) begin
            case (paddr)
                rac_pkg::ADDR_CTRL_CAL: begin
                    if (pstrb[0]) begin
                        s_d.cal = pwdata[7:0];
                    end
                    if (pstrb[1]) begin
                        s_d.run  = pwdata[rac_pkg::CTRL_RUN_BIT];
                        s_d.wren = pwdata[rac_pkg::CTRL_WREN_BIT];
                    end
                end
                rac_pkg::ADDR_ALARM_CFG: begin
                    if (pstrb[0]) begin
                        s_d.rpt = pwdata[7:0];
                    end
                    if (pstrb[1]) begin
                        s_d.al_en = pwdata[rac_pkg::CFG_EN_BIT];
                        s_d.chime = pwdata[rac_pkg::CFG_CHIME_BIT];
                        s_d.mask  = pwdata[rac_pkg::CFG_MASK_LSB +: 4];
                        s_d.ptr   = pwdata[rac_pkg::CFG_PTR_LSB +: 2];
                    end
                end
                rac_pkg::ADDR_ALARM_PORT: begin
                    case (s_q.ptr)
                        rac_pkg::PTR_MIN_SEC:
                            s_d.al_ms = merge(s_q.al_ms, pwdata, pstrb, rac_pkg::MS_BITS);
                        rac_pkg::PTR_WDHR:
                            s_d.al_wh = s_q.wren ? wh_w : s_q.al_wh;
                        rac_pkg::PTR_MTHDY:
                            s_d.al_md = s_q.wren ? md_w : s_q.al_md;
                        default: ;
                    endcase
                end
                rac_pkg::ADDR_TIME_MS:
                    s_d.time_ms = merge(s_q.time_ms, pwdata, pstrb, rac_pkg::MS_BITS);
                rac_pkg::ADDR_AL_MD:
                    s_d.al_md = s_q.wren ? md_w : s_q.al_md;
                rac_pkg::ADDR_AL_WH:
                    s_d.al_wh = s_q.wren ? wh_w : s_q.al_wh;
                rac_pkg::ADDR_AL_MS:
                    s_d.al_ms = merge(s_q.al_ms, pwdata, pstrb, rac_pkg::MS_BITS);
                default: ;
            endcase
        end
        // A read or an upper-byte write of the value port steps the pointer down
        if (paddr == rac_pkg::ADDR_ALARM_PORT && (rd_acc || (wr_acc && pstrb[1]))
                && s_q.ptr != 2'b00) begin
            s_d.ptr = s_q.ptr - 2'b01;
        end

        // Alarm event one cycle after the time update; hardware wins over software
        if (s_q.tick && s_q.al_en
                && mask_match(s_q, cur_weekday_hours, cur_month_day)) begin
            s_d.irq   = 1'b1;
            s_d.pulse = !s_q.pulse;
            if (s_q.rpt != 8'h00) begin
                s_d.rpt = s_q.rpt - 8'h01;
            end else if (s_q.chime) begin
                s_d.rpt = rac_pkg::RPT_MAX;
            end else begin
                s_d.al_en = 1'b0;
            end
        end

        // Read data and error captured in the setup cycle
        if (setup) begin
            s_d.err = !known_addr(paddr);
            case (paddr)
                rac_pkg::ADDR_CTRL_CAL:
                    s_d.rdata = {16'h0000, s_q.run, 1'b0, s_q.wren, s_q.half, 4'h0, s_q.cal};
                rac_pkg::ADDR_ALARM_CFG:
                    s_d.rdata = {16'h0000, s_q.al_en, s_q.chime, s_q.mask, s_q.ptr, s_q.rpt};
                rac_pkg::ADDR_ALARM_PORT: s_d.rdata = {16'h0000, port_view(s_q)};
                rac_pkg::ADDR_TIME_MS:    s_d.rdata = {16'h0000, s_q.time_ms};
                rac_pkg::ADDR_AL_MD:      s_d.rdata = {16'h0000, s_q.al_md};
                rac_pkg::ADDR_AL_WH:      s_d.rdata = {16'h0000, s_q.al_wh};
                rac_pkg::ADDR_AL_MS:      s_d.rdata = {16'h0000, s_q.al_ms};
                default:                  s_d.rdata = 32'h00000000;
            endcase
        end
    end

    // ==================================================================
    // State register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_q       <= '0;
            s_q.cal   <= rac_pkg::CAL_RST;
            s_q.al_md <= rac_pkg::VALUE_RST;
            s_q.al_wh <= rac_pkg::VALUE_RST;
            s_q.al_ms <= rac_pkg::VALUE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign pready       = 1'b1;
    assign prdata       = s_q.rdata;
    assign pslverr      = s_q.err;
    assign alarm_irq    = s_q.irq;
    assign alarm_pulse  = s_q.pulse;
    assign minute_carry = s_q.min_pulse;

    // ==================================================================
    // Assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    property p_time_bcd;
        tick && !wr_acc && s_q.time_ms[6:4] <= 3'h5 && s_q.time_ms[3:0] <= 4'h9
            |=> s_q.time_ms[6:4] <= 3'h5 && s_q.time_ms[3:0] <= 4'h9;
    endproperty
    a_time_bcd: assert property (p_time_bcd) else $error("seconds tens above 5");

    property p_al_ms_resv;
        (s_q.al_ms & ~rac_pkg::MS_BITS) == 16'h0000;
    endproperty
    a_al_ms_resv: assert property (p_al_ms_resv) else $error("alarm min/sec reserved set");

    property p_md_resv;
        (s_q.al_md & ~rac_pkg::MD_BITS) == 16'h0000 && (s_q.al_wh & ~rac_pkg::WH_BITS) == 16'h0000;
    endproperty
    a_md_resv: assert property (p_md_resv) else $error("alarm date reserved set");

    property p_wren_gate;
        wr_acc && paddr == rac_pkg::ADDR_AL_MD && !s_q.wren |=> $stable(s_q.al_md);
    endproperty
    a_wren_gate: assert property (p_wren_gate) else $error("locked month/day written");

    property p_cal_load;
        s_q.min_pulse |-> s_q.presc == {{8{s_q.cal[7]}}, s_q.cal, 2'b00};
    endproperty
    a_cal_load: assert property (p_cal_load) else $error("calibration not applied");

    property p_needs_enable;
        s_q.irq |-> $past(s_q.al_en) && $past(s_q.tick);
    endproperty
    a_needs_enable: assert property (p_needs_enable) else $error("alarm while disabled");

    property p_last_alarm;
        s_q.irq && $past(s_q.rpt) == 8'h00 && !$past(s_q.chime) |-> !s_q.al_en;
    endproperty
    a_last_alarm: assert property (p_last_alarm) else $error("final alarm kept enable");

    property p_chime_wrap;
        s_q.irq && $past(s_q.rpt) == 8'h00 && $past(s_q.chime) |-> s_q.rpt == 8'hFF;
    endproperty
    a_chime_wrap: assert property (p_chime_wrap) else $error("chime counter no wrap");

    sequence s_event;
        s_q.irq ##0 $past(s_q.rpt) != 8'h00;
    endsequence
    property p_decrement;
        s_event ##0 !$past(wr_acc) |-> s_q.rpt == $past(s_q.rpt) - 8'h01;
    endproperty
    a_decrement: assert property (p_decrement) else $error("repeat count not decremented");

    property p_pulse;
        s_q.irq |-> alarm_pulse != $past(alarm_pulse);
    endproperty
    a_pulse: assert property (p_pulse) else $error("alarm pulse did not toggle");

    property p_ptr_dec;
        rd_acc && paddr == rac_pkg::ADDR_ALARM_PORT && s_q.ptr != 2'b00
            |=> s_q.ptr == $past(s_q.ptr) - 2'b01;
    endproperty
    a_ptr_dec: assert property (p_ptr_dec) else $error("window pointer not stepped");
endmodule

// ==== include/rac_pkg.sv ====
// Package: register map, field layout and timing constants for the clock alarm block
package rac_pkg;
    // ==================================================================
    // Timing
    localparam int unsigned CLK_PERIOD_NS  = 100;
    localparam int unsigned OSC_PERIOD_PS  = 30517;
    localparam int unsigned OSC_DIV_CYC    = (OSC_PERIOD_PS / 1000 + CLK_PERIOD_NS - 1)
                                             / CLK_PERIOD_NS * 0 + OSC_PERIOD_PS
                                             / (CLK_PERIOD_NS * 1000) * 0 + 305;
    localparam int unsigned HALF_SEC_PULSES = 16384;
    localparam int unsigned CAL_UNIT_PULSES = 4;

    // ==================================================================
    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL_CAL   = 8'h00;
    localparam logic [7:0] ADDR_ALARM_CFG  = 8'h04;
    localparam logic [7:0] ADDR_ALARM_PORT = 8'h08;
    localparam logic [7:0] ADDR_TIME_MS    = 8'h0C;
    localparam logic [7:0] ADDR_AL_MD      = 8'h10;
    localparam logic [7:0] ADDR_AL_WH      = 8'h14;
    localparam logic [7:0] ADDR_AL_MS      = 8'h18;

    // ==================================================================
    // Control/calibration fields
    localparam int unsigned CTRL_RUN_BIT  = 15;
    localparam int unsigned CTRL_WREN_BIT = 13;
    localparam int unsigned CTRL_HALF_BIT = 12;

    // ==================================================================
    // Alarm configuration fields
    localparam int unsigned CFG_EN_BIT    = 15;
    localparam int unsigned CFG_CHIME_BIT = 14;
    localparam int unsigned CFG_MASK_LSB  = 10;
    localparam int unsigned CFG_PTR_LSB   = 8;

    // ==================================================================
    // Implemented bits of the value registers
    localparam logic [15:0] MS_BITS = 16'h7F7F;
    localparam logic [15:0] MD_BITS = 16'h1F3F;
    localparam logic [15:0] WH_BITS = 16'h073F;

    // ==================================================================
    // Reset values and repeat counter wrap value
    localparam logic [15:0] VALUE_RST = 16'h0000;
    localparam logic [7:0]  RPT_MAX   = 8'hFF;
    localparam logic [7:0]  CAL_RST   = 8'h00;

    // ==================================================================
    // Match intervals and window pointer codes
    typedef enum logic [3:0] {
        RAC_M_HALF, RAC_M_SEC, RAC_M_10SEC, RAC_M_MIN, RAC_M_10MIN,
        RAC_M_HOUR, RAC_M_DAY, RAC_M_WEEK, RAC_M_MONTH, RAC_M_YEAR
    } rac_mask_e;

    localparam logic [1:0] PTR_MIN_SEC = 2'b00;
    localparam logic [1:0] PTR_WDHR    = 2'b01;
    localparam logic [1:0] PTR_MTHDY   = 2'b10;
endpackage

// ==== verif/rac_alarm_tb.sv ====
// Self-checking bench for the clock alarm block
`timescale 1ns/1ps
module rac_alarm_tb;
    // ==================================================================
    // Signals
    localparam int HP = 600;
    logic        ref_clk = 1'b0;
    logic        reset = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0]  pstrb = 4'h0;
    logic [15:0] cur_wh = 16'h0000;
    logic [15:0] cur_md = 16'h0000;
    logic        pready;
    logic        pslverr;
    logic        alarm_irq;
    logic        alarm_pulse;
    logic        minute_carry;
    logic        pulse_prev = 1'b0;
    logic        er;
    logic [31:0] prdata;
    logic [31:0] rd;
    int          n_fail = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          n_irq = 0;
    int          n_tog = 0;
    int          n_carry = 0;
    int          t_last = 0;
    int          t_prev = 0;

    rac_alarm #(.OSC_DIV(1), .HALF_PULSES(HP)) i_rac_alarm (
        .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .cur_weekday_hours(cur_wh), .cur_month_day(cur_md),
        .alarm_irq(alarm_irq), .alarm_pulse(alarm_pulse), .minute_carry(minute_carry)
    );

    always #50 ref_clk = ~ref_clk;

    // ==================================================================
    // Event monitor
    always @(posedge ref_clk) begin
        cyc++;
        if (alarm_irq === 1'b1) begin
            n_irq++;
            t_prev = t_last;
            t_last = cyc;
        end
        if (alarm_pulse !== pulse_prev) n_tog++;
        pulse_prev = alarm_pulse;
        if (minute_carry === 1'b1) n_carry++;
    end

    // ==================================================================
    // Bus and compare tasks
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'h3;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) begin
            @(posedge ref_clk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
        checks_done++;
        if (g < lo || g > hi) begin
            n_fail++;
            $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000);
        chk(nm, e, rd);
    endtask

    // ==================================================================
    // Scenarios
    task automatic t_reset;
        rchk("ctrl", rac_pkg::ADDR_CTRL_CAL, 32'h00000000);
        rchk("cfg", rac_pkg::ADDR_ALARM_CFG, 32'h00000000);
        rchk("time", rac_pkg::ADDR_TIME_MS, 32'h00000000);
        rchk("unmapped", 8'h1C, 32'h00000000);
        chk("slverr", 32'h00000001, {31'h00000000, er});
        $display("test reset done");
    endtask

    task automatic t_values;
        wr(rac_pkg::ADDR_TIME_MS, 32'h0000FFFF);
        rchk("time bits", rac_pkg::ADDR_TIME_MS, 32'h00007F7F);
        wr(rac_pkg::ADDR_AL_MS, 32'h0000FFFF);
        rchk("alarm ms", rac_pkg::ADDR_AL_MS, 32'h00007F7F);
        wr(rac_pkg::ADDR_AL_MD, 32'h0000FFFF);
        rchk("md locked", rac_pkg::ADDR_AL_MD, 32'h00000000);
        wr(rac_pkg::ADDR_CTRL_CAL, 32'h00002000);
        wr(rac_pkg::ADDR_AL_MD, 32'h0000FFFF);
        rchk("md bits", rac_pkg::ADDR_AL_MD, 32'h00001F3F);
        wr(rac_pkg::ADDR_AL_WH, 32'h0000FFFF);
        rchk("wh bits", rac_pkg::ADDR_AL_WH, 32'h0000073F);
        $display("test values done");
    endtask

    task automatic t_port;
        wr(rac_pkg::ADDR_ALARM_CFG, 32'h00000200);
        rchk("port md", rac_pkg::ADDR_ALARM_PORT, 32'h00001F3F);
        rchk("port wh", rac_pkg::ADDR_ALARM_PORT, 32'h0000073F);
        rchk("port ms", rac_pkg::ADDR_ALARM_PORT, 32'h00007F7F);
        rchk("port hold", rac_pkg::ADDR_ALARM_PORT, 32'h00007F7F);
        rchk("ptr zero", rac_pkg::ADDR_ALARM_CFG, 32'h00000000);
        wr(rac_pkg::ADDR_ALARM_CFG, 32'h00000100);
        wr(rac_pkg::ADDR_ALARM_PORT, 32'h00000512);
        rchk("port write", rac_pkg::ADDR_AL_WH, 32'h00000512);
        rchk("ptr stepped", rac_pkg::ADDR_ALARM_CFG, 32'h00000000);
        $display("test port done");
    endtask

    task automatic t_once;
        logic [7:0] rpt [2] = '{8'h00, 8'h02};
        wr(rac_pkg::ADDR_AL_MS, 32'h00000000);
        wr(rac_pkg::ADDR_TIME_MS, 32'h00000000);
        for (int i = 0; i < 2; i++) begin
            n_irq = 0;
            n_tog = 0;
            wr(rac_pkg::ADDR_ALARM_CFG, {16'h0000, 8'h84, rpt[i]});
            wr(rac_pkg::ADDR_CTRL_CAL, 32'h0000A000);
            repeat (8 * HP) @(posedge ref_clk);
            wr(rac_pkg::ADDR_CTRL_CAL, 32'h00002000);
            chk("alarms", 32'(rpt[i]) + 1, n_irq);
            chk("toggles", 32'(rpt[i]) + 1, n_tog);
            rchk("cfg off", rac_pkg::ADDR_ALARM_CFG, 32'h00000400);
        end
        $display("test once done");
    endtask

    task automatic t_masks;
        logic [3:0] m [4] = '{4'h0, 4'h1, 4'hA, 4'hF};
        int e [4] = '{6, 3, 0, 0};
        for (int i = 0; i < 4; i++) begin
            n_irq = 0;
            n_tog = 0;
            wr(rac_pkg::ADDR_ALARM_CFG, {16'h0000, 2'b11, m[i], 10'h000});
            wr(rac_pkg::ADDR_CTRL_CAL, 32'h0000A000);
            repeat (6 * HP) @(posedge ref_clk);
            wr(rac_pkg::ADDR_CTRL_CAL, 32'h00002000);
            repeat (3) @(posedge ref_clk);
            chk_rng("mask rate", e[i] == 0 ? 0 : e[i] - 1, e[i] + 1, n_irq);
            chk("toggles", n_irq, n_tog);
            rchk("chime wrap", rac_pkg::ADDR_ALARM_CFG,
                 {16'h0000, 2'b11, m[i], 2'b00, 8'(0 - n_irq)});
        end
        $display("test masks done");
    endtask

    task automatic t_cal;
        logic [7:0] cal [3] = '{8'h00, 8'hFF, 8'h02};
        for (int i = 0; i < 3; i++) begin
            wr(rac_pkg::ADDR_CTRL_CAL, 32'h00002000);
            wr(rac_pkg::ADDR_ALARM_CFG, 32'h00000000);
            wr(rac_pkg::ADDR_TIME_MS, 32'h00005959);
            wr(rac_pkg::ADDR_ALARM_CFG, 32'h0000C000);
            n_carry = 0;
            wr(rac_pkg::ADDR_CTRL_CAL, {16'h0000, 8'hA0, cal[i]});
            while (n_carry == 0) begin
                @(posedge ref_clk);
            end
            // Wrap alarm and the one after it, not a third
            repeat (HP + HP / 2) @(posedge ref_clk);
            chk("half after wrap", 32'(HP - 4 * int'($signed(cal[i]))),
                32'(t_last - t_prev));
            chk("carry", 32'h00000001, 32'(n_carry));
        end
        wr(rac_pkg::ADDR_CTRL_CAL, 32'h00002000);
        $display("test calibration done");
    endtask

    // ==================================================================
    // Run control
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge ref_clk);
        n_fail++;
        $display("watchdog expired");
        final_report();
    end

    initial begin
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        t_reset();
        t_values();
        t_port();
        t_once();
        t_masks();
        t_cal();
        final_report();
    end
endmodule
